// ---- src/ledfb_pkg.sv ----
// Constants, register map and carrier types of the foldback/dimming bank
package ledfb_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned DIM_STEPS       = 200;
  localparam int unsigned DIM_FREQ0_HZ    = 200;
  localparam int unsigned DIM_FREQ1_HZ    = 250;
  localparam int unsigned DIM_FREQ2_HZ    = 300;
  localparam int unsigned DIM_FREQ3_HZ    = 350;
  localparam int unsigned DEAD1_NS        = 10;
  localparam int unsigned DEAD2_NS        = 20;
  localparam int unsigned DEAD3_NS        = 40;
  // Least dead times round up to whole cycles
  localparam int unsigned DEAD1_CYC =
    (DEAD1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEAD2_CYC =
    (DEAD2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEAD3_CYC =
    (DEAD3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Addressing: page (indirect) plus direct address
  localparam logic [7:0] PAGE_1A = 8'h1a;
  localparam logic [7:0] PAGE_1B = 8'h1b;
  localparam logic [7:0] PAGE_1C = 8'h1c;
  localparam logic [7:0] PAGE_1D = 8'h1d;
  localparam logic [7:0] PAGE_1E = 8'h1e;
  localparam logic [7:0] DIR_07  = 8'h07;
  localparam logic [7:0] DIR_06  = 8'h06;
  localparam logic [7:0] DIR_05  = 8'h05;

  localparam int unsigned NREG = 13;
  localparam logic [3:0] IDX_NONE = 4'hd;

  // Register index order
  localparam logic [3:0] IDX_BIN2_TEMP  = 4'h0;
  localparam logic [3:0] IDX_BIN3_TEMP  = 4'h1;
  localparam logic [3:0] IDX_BIN4_TEMP  = 4'h2;
  localparam logic [3:0] IDX_BIN1_SUP   = 4'h3;
  localparam logic [3:0] IDX_BIN2_SUP   = 4'h4;
  localparam logic [3:0] IDX_BIN3_SUP   = 4'h5;
  localparam logic [3:0] IDX_BIN4_SUP   = 4'h6;
  localparam logic [3:0] IDX_SUP_FB     = 4'h7;
  localparam logic [3:0] IDX_DIM_CTRL   = 4'h8;
  localparam logic [3:0] IDX_DIM_DUTY   = 4'h9;
  localparam logic [3:0] IDX_GATE_BEAM  = 4'ha;
  localparam logic [3:0] IDX_HB_OV      = 4'hb;
  localparam logic [3:0] IDX_LB_OV      = 4'hc;

  typedef logic [7:0] ledfb_byte_t;
  typedef ledfb_byte_t ledfb_tab_t [NREG];

  // Writable bits; all others are reserved
  localparam ledfb_tab_t REG_MASK = '{
    8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f,
    8'h3f, 8'he3, 8'hff, 8'h0f, 8'h3f, 8'h1f};
  localparam ledfb_tab_t REG_RESET = '{
    8'h08, 8'h03, 8'h00, 8'h07, 8'h05, 8'h02, 8'h01,
    8'h23, 8'h00, 8'h00, 8'h00, 8'h1f, 8'h1f};

  // ==========================================================================
  // Field positions
  localparam int unsigned SLOPE_MSB     = 4;
  localparam int unsigned DERATE_LSB    = 3;
  localparam int unsigned THRESH_LSB    = 0;
  localparam int unsigned DIM_EN_BIT    = 7;
  localparam int unsigned DIM_RATE_LSB  = 5;
  localparam int unsigned DIM_DRV_LSB   = 0;
  localparam int unsigned DEAD_LSB      = 2;
  localparam int unsigned POL_BIT       = 1;
  localparam int unsigned FORCE_BIT     = 0;
  localparam int unsigned OVB_BIT       = 5;
  localparam int unsigned OV_LVL_MSB    = 4;

  // ==========================================================================
  // Configuration carrier to the analog side
  typedef struct packed {
    logic [3:0][4:0] temp_slope_factor;   // Bin 1 entry unused (zero)
    logic [3:0][4:0] supply_slope_factor;
    logic [2:0]      supply_derating_factor;
    logic [2:0]      supply_foldback_threshold;
    logic            internal_dim_enable;
    logic [1:0]      internal_dim_rate;
    logic [1:0]      dim_switch_drive_strength;
    logic [7:0]      internal_dim_duty;
    logic [1:0]      extra_dead_time;
    logic [2:0]      extra_dead_cycles;
    logic            beam_gate_polarity;
    logic            beam_gate_force_on;
    logic            overvolt_driver_behaviour;
    logic [4:0]      high_beam_overvolt_level;
    logic [4:0]      low_beam_overvolt_level;
  } ledfb_cfg_t;

endpackage : ledfb_pkg

// ---- src/ledfb_dim_gen.sv ----
// Internal dimming generator: 200-step duty over a selectable period
`timescale 1ns/1ns
module ledfb_dim_gen
  import ledfb_pkg::*;
#(
  parameter int unsigned DIM_CLK_HZ = CLK_HZ
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  // Settings
  input  wire logic       enable_in,
  input  wire logic [1:0] rate_in,
  input  wire logic [7:0] duty_in,
  // Dimming output
  output logic            dim_out
);

  // ==========================================================================
  // Step lengths per rate code
  localparam int unsigned DIV0 = DIM_CLK_HZ / (DIM_FREQ0_HZ * DIM_STEPS);
  localparam int unsigned DIV1 = DIM_CLK_HZ / (DIM_FREQ1_HZ * DIM_STEPS);
  localparam int unsigned DIV2 = DIM_CLK_HZ / (DIM_FREQ2_HZ * DIM_STEPS);
  localparam int unsigned DIV3 = DIM_CLK_HZ / (DIM_FREQ3_HZ * DIM_STEPS);
  localparam logic [7:0]  LAST_STEP = 8'(DIM_STEPS - 1);
  localparam logic [7:0]  FULL_DUTY = 8'(DIM_STEPS);

  logic [15:0] pre_q;
  logic [7:0]  step_q;
  logic        out_q;
  logic [15:0] div_last;
  logic [7:0]  duty_eff;
  logic        pre_wrap;

  assign div_last = (rate_in == 2'h0) ? 16'(DIV0 - 1) :
                    (rate_in == 2'h1) ? 16'(DIV1 - 1) :
                    (rate_in == 2'h2) ? 16'(DIV2 - 1) : 16'(DIV3 - 1);
  // Codes past full scale clamp to always on
  assign duty_eff = (duty_in > FULL_DUTY) ? FULL_DUTY : duty_in;
  // Rate change mid-step: compare with >= so a shorter step still wraps
  assign pre_wrap = (pre_q >= div_last);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !enable_in) begin
      pre_q  <= 16'h0000;
      step_q <= 8'h00;
      out_q  <= 1'b0;
    end else begin
      pre_q <= pre_wrap ? 16'h0000 : pre_q + 16'h0001;
      if (pre_wrap) begin
        step_q <= (step_q == LAST_STEP) ? 8'h00 : step_q + 8'h01;
      end
      out_q <= (step_q < duty_eff);
    end
  end

  assign dim_out = out_q;

  // ==========================================================================
  // Checks
  a_dim_off_disabled: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !enable_in |=> !dim_out)
    else $error("dimming output high while disabled");

  a_dim_full_on: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    (enable_in && $past(enable_in) && duty_in >= FULL_DUTY
     && $past(duty_in) >= FULL_DUTY) |=> dim_out)
    else $error("full duty did not hold output on");

endmodule : ledfb_dim_gen

// ---- src/ledfb_cfg_bank.sv ----
// Foldback, dimming and beam gate configuration register bank
`timescale 1ns/1ns
// Overview of operation
// - Bins two to four hold 5-bit temperature slopes, defaults 8, 3, 0.
// - Four 5-bit supply slopes, defaults 7, 5, 2, 1.
// - Bits 5:3 select supply derating factor, reset code 4.
// - 3-bit field picks foldback start voltage 7.5 V to 11 V, reset 3.
// - Bit 7 enables internal dimming, reset off.
// - 2-bit rate code selects 200, 250, 300 or 350 Hz, reset 0.
// - 2-bit dimming switch drive strength code, reset 0.
// - 8-bit duty, 0.5 percent steps, 200 is fully on, reset 0.
// - 2-bit extra dead time 0, 10, 20 or 40 ns, reset 0.
// - Polarity bit: clear keeps gate off, set turns it on, pin low.
// - Force bit drives high-beam gate on regardless of pin, reset clear.
// - Overvoltage behaviour select bit, resets to zero.
// - 5-bit high-beam overvoltage level, 20.4 V plus 1.6 V steps, reset 31.
// - 5-bit low-beam overvoltage level, 10.4 V plus 1.6 V steps, reset 31.
module ledfb_cfg_bank
  import ledfb_pkg::*;
#(
  parameter int unsigned DIM_CLK_HZ = CLK_HZ
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  // Register access
  input  wire logic       reg_wr_en_in,
  input  wire logic       reg_rd_en_in,
  input  wire logic [7:0] page_addr_in,
  input  wire logic [7:0] direct_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_hit_out,
  // Beam select pin
  input  wire logic       beam_select_pin_in,
  // Gates and settings
  output logic            high_beam_gate_out,
  output logic            internal_dim_out,
  output ledfb_cfg_t      cfg_out
);

  // ==========================================================================
  // Address decode
  function automatic logic [3:0] reg_index(input logic [7:0] page,
                                           input logic [7:0] dir);
    logic [3:0] col;
    logic [3:0] base;
    col  = 4'hf;
    base = 4'h0;
    if (dir == DIR_07) begin
      col = 4'h0;
    end else if (dir == DIR_06) begin
      col = 4'h1;
    end else if (dir == DIR_05) begin
      col = 4'h2;
    end
    if (page == PAGE_1A) begin
      base = 4'h0;
    end else if (page == PAGE_1B) begin
      base = 4'h3;
    end else if (page == PAGE_1C) begin
      base = 4'h6;
    end else if (page == PAGE_1D) begin
      base = 4'h9;
    end else if (page == PAGE_1E && dir == DIR_07) begin
      base = 4'hc;
    end else begin
      col = 4'hf;
    end
    // Page 0x1e holds a single register here
    if (col == 4'hf) begin
      reg_index = IDX_NONE;
    end else begin
      reg_index = base + col;
    end
  endfunction : reg_index

  logic [3:0] acc_idx;
  logic       acc_hit;
  assign acc_idx = reg_index(page_addr_in, direct_addr_in);
  assign acc_hit = (acc_idx != IDX_NONE);

  // ==========================================================================
  // Register storage
  ledfb_byte_t regs_q [NREG];
  logic [7:0]  rdata_q;
  logic        hit_q;
  logic [7:0]  rd_word;

  // Only writable bits are stored, reserved bits stay zero
  assign rd_word = acc_hit ? (regs_q[acc_idx] & REG_MASK[acc_idx])
                           : 8'h00;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= REG_RESET[i];
      end
    end else if (reg_wr_en_in && acc_hit) begin
      regs_q[acc_idx] <= reg_wdata_in & REG_MASK[acc_idx];
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
      hit_q   <= 1'b0;
    end else if (reg_rd_en_in) begin
      rdata_q <= rd_word;
      hit_q   <= acc_hit;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_hit_out   = hit_q;

  // ==========================================================================
  // Field extraction
  logic [1:0] dead_code;
  assign dead_code = regs_q[IDX_GATE_BEAM][DEAD_LSB+1:DEAD_LSB];

  always_comb begin
    cfg_out = '0;
    cfg_out.temp_slope_factor[1] = regs_q[IDX_BIN2_TEMP][SLOPE_MSB:0];
    cfg_out.temp_slope_factor[2] = regs_q[IDX_BIN3_TEMP][SLOPE_MSB:0];
    cfg_out.temp_slope_factor[3] = regs_q[IDX_BIN4_TEMP][SLOPE_MSB:0];
    cfg_out.supply_slope_factor[0] = regs_q[IDX_BIN1_SUP][SLOPE_MSB:0];
    cfg_out.supply_slope_factor[1] = regs_q[IDX_BIN2_SUP][SLOPE_MSB:0];
    cfg_out.supply_slope_factor[2] = regs_q[IDX_BIN3_SUP][SLOPE_MSB:0];
    cfg_out.supply_slope_factor[3] = regs_q[IDX_BIN4_SUP][SLOPE_MSB:0];
    cfg_out.supply_derating_factor =
      regs_q[IDX_SUP_FB][DERATE_LSB+2:DERATE_LSB];
    cfg_out.supply_foldback_threshold =
      regs_q[IDX_SUP_FB][THRESH_LSB+2:THRESH_LSB];
    cfg_out.internal_dim_enable = regs_q[IDX_DIM_CTRL][DIM_EN_BIT];
    cfg_out.internal_dim_rate =
      regs_q[IDX_DIM_CTRL][DIM_RATE_LSB+1:DIM_RATE_LSB];
    cfg_out.dim_switch_drive_strength =
      regs_q[IDX_DIM_CTRL][DIM_DRV_LSB+1:DIM_DRV_LSB];
    cfg_out.internal_dim_duty = regs_q[IDX_DIM_DUTY];
    cfg_out.extra_dead_time   = dead_code;
    cfg_out.extra_dead_cycles =
      (dead_code == 2'h0) ? 3'h0 :
      (dead_code == 2'h1) ? 3'(DEAD1_CYC) :
      (dead_code == 2'h2) ? 3'(DEAD2_CYC) : 3'(DEAD3_CYC);
    cfg_out.beam_gate_polarity = regs_q[IDX_GATE_BEAM][POL_BIT];
    cfg_out.beam_gate_force_on = regs_q[IDX_GATE_BEAM][FORCE_BIT];
    cfg_out.overvolt_driver_behaviour = regs_q[IDX_HB_OV][OVB_BIT];
    cfg_out.high_beam_overvolt_level =
      regs_q[IDX_HB_OV][OV_LVL_MSB:0];
    cfg_out.low_beam_overvolt_level =
      regs_q[IDX_LB_OV][OV_LVL_MSB:0];
  end

  // ==========================================================================
  // High-beam gate
  // Pin is asynchronous; two flops before any logic looks at it
  logic sel_meta_q;
  logic sel_sync_q;
  logic gate_q;
  logic gate_d;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
    end else begin
      sel_meta_q <= beam_select_pin_in;
      sel_sync_q <= sel_meta_q;
    end
  end

  assign gate_d = regs_q[IDX_GATE_BEAM][FORCE_BIT] |
                  (regs_q[IDX_GATE_BEAM][POL_BIT] ? !sel_sync_q
                                                  : sel_sync_q);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
    end
  end

  assign high_beam_gate_out = gate_q;

  // ==========================================================================
  // Internal dimming generator
  ledfb_dim_gen #(
    .DIM_CLK_HZ (DIM_CLK_HZ)
  ) u_dim_gen (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .enable_in  (regs_q[IDX_DIM_CTRL][DIM_EN_BIT]),
    .rate_in    (regs_q[IDX_DIM_CTRL][DIM_RATE_LSB+1:DIM_RATE_LSB]),
    .duty_in    (regs_q[IDX_DIM_DUTY]),
    .dim_out    (internal_dim_out)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_write(logic [7:0] pg, logic [7:0] da);
    reg_wr_en_in && page_addr_in == pg && direct_addr_in == da;
  endsequence

  sequence s_read_back(logic [7:0] pg, logic [7:0] da);
    reg_rd_en_in && !reg_wr_en_in && page_addr_in == pg
      && direct_addr_in == da;
  endsequence

  a_temp_slope_write: assert property (
    s_write(PAGE_1A, DIR_07) |=>
      cfg_out.temp_slope_factor[1] == $past(reg_wdata_in[4:0]))
    else $error("bin two temperature slope not written");

  a_supply_slope_write: assert property (
    s_write(PAGE_1C, DIR_07) |=>
      cfg_out.supply_slope_factor[3] == $past(reg_wdata_in[4:0]))
    else $error("bin four supply slope not written");

  a_derate_field_pos: assert property (
    s_write(PAGE_1C, DIR_06) |=>
      cfg_out.supply_derating_factor == $past(reg_wdata_in[5:3])
      && cfg_out.supply_foldback_threshold == $past(reg_wdata_in[2:0]))
    else $error("derating or threshold field misplaced");

  a_dim_ctrl_fields: assert property (
    s_write(PAGE_1C, DIR_05) |=>
      cfg_out.internal_dim_enable == $past(reg_wdata_in[7])
      && cfg_out.internal_dim_rate == $past(reg_wdata_in[6:5])
      && cfg_out.dim_switch_drive_strength == $past(reg_wdata_in[1:0]))
    else $error("dimming control fields not written");

  a_dead_time_map: assert property (
    cfg_out.extra_dead_time == 2'h3 |-> cfg_out.extra_dead_cycles == 3'h4)
    else $error("40 ns dead time not four cycles");

  a_beam_polarity: assert property (
    (!cfg_out.beam_gate_force_on && !cfg_out.beam_gate_polarity
     && !beam_select_pin_in) [*3] |=> !high_beam_gate_out)
    else $error("gate on while pin low and polarity clear");

  a_beam_inverted: assert property (
    (!cfg_out.beam_gate_force_on && cfg_out.beam_gate_polarity
     && !beam_select_pin_in) [*3] |=> high_beam_gate_out)
    else $error("gate off while pin low and polarity set");

  a_force_gate_on: assert property (
    cfg_out.beam_gate_force_on |=> high_beam_gate_out)
    else $error("forced gate not on");

  a_ov_field_write: assert property (
    s_write(PAGE_1D, DIR_05) |=>
      cfg_out.high_beam_overvolt_level == $past(reg_wdata_in[4:0])
      && cfg_out.overvolt_driver_behaviour == $past(reg_wdata_in[5]))
    else $error("high-beam overvoltage register not written");

  a_reserved_read_zero: assert property (
    s_read_back(PAGE_1E, DIR_07) |=> reg_rdata_out[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

  a_unmapped_read: assert property (
    (reg_rd_en_in && !acc_hit) |=> reg_rdata_out == 8'h00 && !reg_hit_out)
    else $error("unmapped read not zero");

  a_reset_defaults: assert property (
    $fell(sys_rst_in) |-> cfg_out.low_beam_overvolt_level == 5'h1f
      && cfg_out.high_beam_overvolt_level == 5'h1f
      && cfg_out.internal_dim_duty == 8'h00)
    else $error("reset defaults wrong");

  a_beam_follows_pin: assert property (
    (!cfg_out.beam_gate_force_on && !cfg_out.beam_gate_polarity
     && beam_select_pin_in) [*3] |=> high_beam_gate_out)
    else $error("gate off while pin high and polarity clear");

  a_duty_read_back: assert property (
    s_read_back(PAGE_1D, DIR_07) |=>
      reg_rdata_out == $past(regs_q[IDX_DIM_DUTY]) && reg_hit_out)
    else $error("duty register read back wrong");

  a_unmapped_write: assert property (
    (reg_wr_en_in && !acc_hit) |=> cfg_out == $past(cfg_out))
    else $error("unmapped write changed a setting");

  // Read data must stand between reads; software may poll it late
  a_read_data_holds: assert property (
    !reg_rd_en_in |=> $stable(reg_rdata_out) && $stable(reg_hit_out))
    else $error("read data changed without a read");

  a_reserved_stay_zero: assert property (
    (reg_wr_en_in && acc_hit) |=>
      (regs_q[$past(acc_idx)] & ~REG_MASK[$past(acc_idx)]) == 8'h00)
    else $error("reserved bits stored");

  a_dim_disabled_low: assert property (
    !cfg_out.internal_dim_enable |=> !internal_dim_out)
    else $error("dimming output high while enable bit clear");

endmodule : ledfb_cfg_bank

// ---- verification/ledfb_host_model.sv ----
// Host side model that issues single byte register accesses
`timescale 1ns/1ns
module ledfb_host_model (
  // Clock
  input  wire logic       clock_in,
  // Register access to the bank
  output logic            reg_wr_en_out,
  output logic            reg_rd_en_out,
  output logic      [7:0] page_addr_out,
  output logic      [7:0] direct_addr_out,
  output logic      [7:0] reg_wdata_out,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       reg_hit_in
);
  // ==========================================================================
  // Idle state
  initial begin
    reg_wr_en_out   = 1'b0;
    reg_rd_en_out   = 1'b0;
    page_addr_out   = 8'h00;
    direct_addr_out = 8'h00;
    reg_wdata_out   = 8'h00;
  end

  // ==========================================================================
  // One access: strobe for one edge, answer read one cycle later
  task access(input logic wr, input logic [7:0] pg, input logic [7:0] dr,
              input logic [7:0] wd, output logic [7:0] rd, output logic hit);
    @(negedge clock_in);
    reg_wr_en_out   = wr;
    reg_rd_en_out   = ~wr;
    page_addr_out   = pg;
    direct_addr_out = dr;
    reg_wdata_out   = wd;
    @(negedge clock_in);
    reg_wr_en_out   = 1'b0;
    reg_rd_en_out   = 1'b0;
    // Stale bus values flipped so no design can lean on them
    page_addr_out   = ~pg;
    direct_addr_out = ~dr;
    reg_wdata_out   = ~wd;
    rd              = reg_rdata_in;
    hit             = reg_hit_in;
  endtask : access
endmodule : ledfb_host_model

// ---- verification/ledfb_cfg_bank_tb.sv ----
// Self-checking bench of the foldback and dimming register bank
`timescale 1ns/1ns
module ledfb_cfg_bank_tb;
  import ledfb_pkg::*;
  // Dimming clock chosen so every rate gives whole cycles per step
  localparam int unsigned SIM_DIM_HZ = 4_200_000;

  // ==========================================================================
  // Signals
  logic       clock_in    = 1'b0;
  logic       sys_rst_in  = 1'b1;
  logic       pin         = 1'b0;
  logic       wr_en, rd_en, hit, gate, dim, lhit;
  logic [7:0] page, dirs, wdata, rdata, rd;
  ledfb_cfg_t cfg;
  int         num_errors  = 0;
  int         checked     = 0;
  int         seed        = 32'h72fa5801;
  int         model [13];
  int         rst_tab [13] = '{8, 3, 0, 7, 5, 2, 1, 35, 0, 0, 0, 31, 31};
  int         msk_tab [13] = '{31, 31, 31, 31, 31, 31, 31, 63, 227, 255, 15,
                               63, 31};
  int         dead_tab [4] = '{0, 1, 2, 4};
  logic [7:0] up [6] = '{8'h1e, 8'h1e, 8'h19, 8'h1f, 8'h1a, 8'h1d};
  logic [7:0] ud [6] = '{8'h06, 8'h05, 8'h07, 8'h07, 8'h04, 8'h08};

  always #5 clock_in = ~clock_in;

  ledfb_host_model i_ledfb_host_model (
    .clock_in(clock_in), .reg_wr_en_out(wr_en), .reg_rd_en_out(rd_en),
    .page_addr_out(page), .direct_addr_out(dirs), .reg_wdata_out(wdata),
    .reg_rdata_in(rdata), .reg_hit_in(hit));

  ledfb_cfg_bank #(.DIM_CLK_HZ(SIM_DIM_HZ)) i_ledfb_cfg_bank (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_wr_en_in(wr_en),
    .reg_rd_en_in(rd_en), .page_addr_in(page), .direct_addr_in(dirs),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit),
    .beam_select_pin_in(pin), .high_beam_gate_out(gate),
    .internal_dim_out(dim), .cfg_out(cfg));

  // ==========================================================================
  // Helpers
  task report_and_stop;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task timeout;
    num_errors++;
    $display("BAD %0t: wait ran out", $time);
    report_and_stop();
  endtask : timeout

  // Index order gives page 1a..1e, direct 07, 06, 05 in turn
  task wr(input int i, input int v);
    i_ledfb_host_model.access(1'b1, 8'(8'h1a + i / 3), 8'(7 - i % 3),
                              8'(v), rd, lhit);
    model[i] = v & msk_tab[i];
  endtask : wr

  task rdchk(input int i);
    i_ledfb_host_model.access(1'b0, 8'(8'h1a + i / 3), 8'(7 - i % 3),
                              8'h00, rd, lhit);
    chk(16'(rd), 16'(model[i]));
    chk(16'(lhit), 16'h0001);
  endtask : rdchk

  task check_all;
    for (int i = 0; i < 13; i++) rdchk(i);
    chk(16'(cfg.temp_slope_factor[0]), 16'h0000);
    for (int i = 1; i < 4; i++)
      chk(16'(cfg.temp_slope_factor[i]), 16'(model[i-1]));
    for (int i = 0; i < 4; i++)
      chk(16'(cfg.supply_slope_factor[i]), 16'(model[i+3]));
    chk(16'(cfg.supply_derating_factor), 16'((model[7] >> 3) & 7));
    chk(16'(cfg.supply_foldback_threshold), 16'(model[7] & 7));
    chk(16'(cfg.internal_dim_enable), 16'(model[8] >> 7));
    chk(16'(cfg.internal_dim_rate), 16'((model[8] >> 5) & 3));
    chk(16'(cfg.dim_switch_drive_strength), 16'(model[8] & 3));
    chk(16'(cfg.internal_dim_duty), 16'(model[9]));
    chk(16'(cfg.extra_dead_time), 16'((model[10] >> 2) & 3));
    chk(16'(cfg.extra_dead_cycles), 16'(dead_tab[model[10] >> 2 & 3]));
    chk(16'(cfg.beam_gate_polarity), 16'((model[10] >> 1) & 1));
    chk(16'(cfg.beam_gate_force_on), 16'(model[10] & 1));
    chk(16'(cfg.overvolt_driver_behaviour), 16'((model[11] >> 5) & 1));
    chk(16'(cfg.high_beam_overvolt_level), 16'(model[11] & 31));
    chk(16'(cfg.low_beam_overvolt_level), 16'(model[12] & 31));
  endtask : check_all

  task do_reset;
    sys_rst_in = 1'b1;
    repeat (8) @(negedge clock_in);
    sys_rst_in = 1'b0;
    for (int i = 0; i < 13; i++) model[i] = rst_tab[i];
    chk(16'({rdata, hit, gate, dim}), 16'h0000);
    check_all();
    $display("test reset done");
  endtask : do_reset

  // Counts high cycles over one period, starting at a rising edge when 0 < duty < 200
  task meas(input int cps, input int duty);
    int   n;
    int   hi;
    logic last;
    n = 0;
    // A dark or fully lit output has no edges, so only its high count is checked
    if (duty > 0 && duty < 200) begin
      while (dim !== 1'b0 && n < 30000) begin @(negedge clock_in); n++; end
      while (dim !== 1'b1 && n < 30000) begin @(negedge clock_in); n++; end
      if (n >= 30000) timeout();
    end else
      repeat (3) @(negedge clock_in);
    hi = 0;
    for (n = 0; n < 200 * cps; n++) begin
      hi += (dim === 1'b1);
      last = dim;
      @(negedge clock_in);
    end
    chk(16'(hi), 16'((duty > 200 ? 200 : duty) * cps));
    if (duty > 0 && duty < 200) chk(16'({last, dim}), 16'h0001);
  endtask : meas

  // ==========================================================================
  // Main sequence
  initial begin
    int d;
    do_reset();
    // All ones first to hit every reserved bit, then random bytes
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 13; i++)
        wr(i, r == 0 ? 255 : ($random(seed) & 255));
      check_all();
    end
    $display("test readback done");
    do_reset();
    for (int k = 0; k < 6; k++) begin
      i_ledfb_host_model.access(1'b1, up[k], ud[k], 8'hff, rd, lhit);
      i_ledfb_host_model.access(1'b0, up[k], ud[k], 8'h00, rd, lhit);
      chk(16'({rd, lhit}), 16'h0000);
    end
    check_all();
    $display("test unmapped done");
    for (int k = 0; k < 8; k++) begin
      wr(10, ($random(seed) & 12) | (k >> 1));
      pin = k[0];
      repeat (5) @(negedge clock_in);
      chk(16'(gate), 16'(k[1] | (k[0] ^ k[2])));
    end
    $display("test beam gate done");
    d = ($random(seed) & 32'h7f) + 1;
    wr(9, d);
    wr(8, 8'he0);
    meas(60, d);
    d = ($random(seed) & 32'h7f) + 1;
    wr(9, d);
    wr(8, 8'hc3);
    meas(70, d);
    wr(9, 230);
    wr(8, 8'he0);
    meas(60, 230);
    wr(8, 8'h60);
    meas(1, 0);
    check_all();
    $display("test dimming done");
    report_and_stop();
  end
endmodule : ledfb_cfg_bank_tb
